// *** hdl/dsg_defs.svh ***
// Purpose: offsets, field positions, reset values and codes for the deep-sleep gate block
// Assumes: 32-bit register port, byte addresses
// Notes:   definitions only
`ifndef DSG_DEFS_SVH
`define DSG_DEFS_SVH

`define DSG_ADDR_W          12
`define DSG_OFF_RUN_CLK_CFG 12'h060
`define DSG_OFF_RUN_GATE    12'h104
`define DSG_OFF_SLEEP_GATE  12'h114
`define DSG_OFF_DEEP_GATE   12'h124
`define DSG_OFF_IRQ_STATUS  12'h130
`define DSG_OFF_IRQ_ENABLE  12'h134
`define DSG_OFF_IRQ_CLEAR   12'h138

`define DSG_GATE_RESET      32'h0000_0000
`define DSG_GATE_MASK       32'h0107_1013
`define DSG_CFG_RESET       32'h0000_0000
`define DSG_AUTO_GATE_BIT   27
`define DSG_ZERO_WORD       32'h0000_0000

`define DSG_COMP_ZERO_BIT   24
`define DSG_TIMER_TWO_BIT   18
`define DSG_TIMER_ONE_BIT   17
`define DSG_TIMER_ZERO_BIT  16
`define DSG_I2C_ZERO_BIT    12
`define DSG_SYNC_SERIAL_BIT 4
`define DSG_UART_ONE_BIT    1
`define DSG_UART_ZERO_BIT   0

`define DSG_MODE_RUN        2'h0
`define DSG_MODE_SLEEP      2'h1
`define DSG_MODE_DEEP       2'h2

`define DSG_EVT_FAULT       0
`define DSG_EVT_DEEP_ENTRY  1
`define DSG_EVT_GATE_CHANGE 2
`define DSG_EVT_N           3

`endif

// *** hdl/dsg_pkg.sv ***
// Purpose: types shared by the deep-sleep gate block
// Assumes: nothing beyond the defs header
// Notes:   power state is one-hot
package dsg_pkg;

    typedef enum logic [2:0] {
        DSG_ST_RUN   = 3'h1,
        DSG_ST_SLEEP = 3'h2,
        DSG_ST_DEEP  = 3'h4
    } dsg_state_type;

    typedef logic [31:0] dsg_word_type;

endpackage

// *** hdl/dsg_gate_cell.sv ***
// Purpose: clock enable and bus-fault flag for one peripheral
// Assumes: sys_clk_i at 10 MHz, async active-high reset
// Notes:   fault pulses one cycle after a request to a gated-off unit
`timescale 1ns/1ps
`include "dsg_defs.svh"

module dsg_gate_cell
    import dsg_pkg::*;
#(
    parameter int BIT_POS = 0
) (
    // clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         reset_i,
    // selected gate word and access request
    input  wire dsg_word_type eff_word_i,
    input  wire logic         req_i,
    // results
    output logic              gate_en_o,
    output logic              fault_o
);

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            gate_en_o <= 1'b0;
        end else begin
            gate_en_o <= eff_word_i[BIT_POS];
        end
    end

    // access checked against the enable the unit actually has now
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            fault_o <= 1'b0;
        end else begin
            fault_o <= req_i & ~gate_en_o;
        end
    end

endmodule // dsg_gate_cell

// *** hdl/dsg_irq_bank.sv ***
// Purpose: sticky event status, enable mask and level interrupt
// Assumes: clear register is write-one-to-clear
// Notes:   an event in the clearing cycle wins over the clear
`timescale 1ns/1ps
`include "dsg_defs.svh"

module dsg_irq_bank
    import dsg_pkg::*;
#(
    parameter int N = 3
) (
    // clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         reset_i,
    // events and software access
    input  wire logic [N-1:0] event_i,
    input  wire logic         wr_enable_i,
    input  wire logic         wr_clear_i,
    input  wire logic [N-1:0] wr_data_i,
    // state
    output logic [N-1:0]      status_o,
    output logic [N-1:0]      enable_o,
    output logic              irq_o
);

    logic [N-1:0] next_status;

    always_comb begin
        next_status = status_o;
        if (wr_clear_i) begin
            next_status = next_status & ~wr_data_i;
        end
        next_status = next_status | event_i;
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            status_o <= '0;
        end else begin
            status_o <= next_status;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            enable_o <= '0;
        end else if (wr_enable_i) begin
            enable_o <= wr_data_i;
        end
    end

    // output follows the new status so it stays a single flop
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(next_status & (wr_enable_i ? wr_data_i : enable_o));
        end
    end

endmodule // dsg_irq_bank

// *** hdl/dsg_gate_ctrl.sv ***
// Purpose: peripheral clock gating for run, sleep and deep-sleep
// Assumes: power mode and access requests are synchronous to sys_clk_i
// Notes:   gate enables lag a register write or mode change by two cycles
`timescale 1ns/1ps
`include "dsg_defs.svh"

// Behaviour
// - bit 24 of the deep-sleep gate register enables comparator 0 in deep-sleep.
// - bit 18 gates general-purpose timer 2 in deep-sleep.
// - bit 17 gates general-purpose timer 1 in deep-sleep.
// - bit 16 gates general-purpose timer 0 in deep-sleep.
// - bit 12 gates the I2C unit 0 in deep-sleep.
// - bit 4 gates synchronous serial unit 0 in deep-sleep.
// - bit 1 gates UART 1 in deep-sleep.
// - bit 0 gates UART 0 in deep-sleep.
// - a set bit clocks its unit, a clear bit leaves it unclocked and disabled.
// - an access to an unclocked unit answers with a bus fault.
// - every gate bit resets to zero so all units start unclocked.
// - reserved bits are read-only and read zero; software preserves them.
// - the deep-sleep register acts only in deep-sleep; run and sleep have their own.
// - sleep and deep-sleep registers act only while auto gating select is set.
module dsg_gate_ctrl
    import dsg_pkg::*;
#(
    parameter int NUM_UNITS = 8
) (
    // clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   reset_i,
    // register port
    input  wire logic [`DSG_ADDR_W-1:0] addr_i,
    input  wire logic [31:0]            wr_data_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [31:0]            rd_data_o,
    // power mode from the system controller
    input  wire logic [1:0]             power_mode_i,
    // peripheral side
    input  wire logic [NUM_UNITS-1:0]   unit_req_i,
    output logic      [NUM_UNITS-1:0]   gate_en_o,
    output logic      [NUM_UNITS-1:0]   bus_fault_o,
    // interrupt
    output logic                        irq_o
);

    // unit index to register bit
    localparam int GATE_POS [NUM_UNITS] = '{
        `DSG_UART_ZERO_BIT,
        `DSG_UART_ONE_BIT,
        `DSG_SYNC_SERIAL_BIT,
        `DSG_I2C_ZERO_BIT,
        `DSG_TIMER_ZERO_BIT,
        `DSG_TIMER_ONE_BIT,
        `DSG_TIMER_TWO_BIT,
        `DSG_COMP_ZERO_BIT
    };

    dsg_word_type  run_gate_ctrl_one;
    dsg_word_type  sleep_gate_ctrl_one;
    dsg_word_type  deep_sleep_gate_ctrl_one;
    dsg_word_type  run_clock_config;
    dsg_word_type  eff_word;
    dsg_word_type  next_rd_data;
    dsg_state_type state;
    dsg_state_type next_state;
    logic          auto_gating_select;
    logic [`DSG_EVT_N-1:0] irq_event;
    logic [`DSG_EVT_N-1:0] irq_status;
    logic [`DSG_EVT_N-1:0] irq_enable;
    logic          wr_irq_enable;
    logic          wr_irq_clear;
    logic          gate_change;

    assign auto_gating_select = run_clock_config[`DSG_AUTO_GATE_BIT];

    // write decode
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            run_gate_ctrl_one <= `DSG_GATE_RESET;
        end else if (wr_i && addr_i == `DSG_OFF_RUN_GATE) begin
            run_gate_ctrl_one <= wr_data_i & `DSG_GATE_MASK;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sleep_gate_ctrl_one <= `DSG_GATE_RESET;
        end else if (wr_i && addr_i == `DSG_OFF_SLEEP_GATE) begin
            sleep_gate_ctrl_one <= wr_data_i & `DSG_GATE_MASK;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            deep_sleep_gate_ctrl_one <= `DSG_GATE_RESET;
        end else if (wr_i && addr_i == `DSG_OFF_DEEP_GATE) begin
            deep_sleep_gate_ctrl_one <= wr_data_i & `DSG_GATE_MASK;
        end
    end

    // only the auto gating select bit is held here
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            run_clock_config <= `DSG_CFG_RESET;
        end else if (wr_i && addr_i == `DSG_OFF_RUN_CLK_CFG) begin
            run_clock_config <= `DSG_ZERO_WORD;
            run_clock_config[`DSG_AUTO_GATE_BIT] <= wr_data_i[`DSG_AUTO_GATE_BIT];
        end
    end

    assign wr_irq_enable = wr_i && addr_i == `DSG_OFF_IRQ_ENABLE;
    assign wr_irq_clear  = wr_i && addr_i == `DSG_OFF_IRQ_CLEAR;

    // power state tracker
    always_comb begin
        case (power_mode_i)
            `DSG_MODE_SLEEP: next_state = DSG_ST_SLEEP;
            `DSG_MODE_DEEP:  next_state = DSG_ST_DEEP;
            default:         next_state = DSG_ST_RUN;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= DSG_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // bank select for the current state
    always_comb begin
        eff_word = run_gate_ctrl_one;
        case (state)
            DSG_ST_SLEEP: begin
                if (auto_gating_select) begin
                    eff_word = sleep_gate_ctrl_one;
                end
            end
            DSG_ST_DEEP: begin
                if (auto_gating_select) begin
                    eff_word = deep_sleep_gate_ctrl_one;
                end
            end
            default: eff_word = run_gate_ctrl_one;
        endcase
    end

    // one cell per unit: enable flop and fault flag
    for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
        dsg_gate_cell #(
            .BIT_POS (GATE_POS[g])
        ) u_cell (
            .sys_clk_i  (sys_clk_i),
            .reset_i    (reset_i),
            .eff_word_i (eff_word),
            .req_i      (unit_req_i[g]),
            .gate_en_o  (gate_en_o[g]),
            .fault_o    (bus_fault_o[g])
        );
    end

    // events for the interrupt bank
    always_comb begin
        gate_change = 1'b0;
        for (int i = 0; i < NUM_UNITS; i++) begin
            if (gate_en_o[i] != eff_word[GATE_POS[i]]) begin
                gate_change = 1'b1;
            end
        end
    end

    assign irq_event[`DSG_EVT_FAULT]       = |(unit_req_i & ~gate_en_o);
    assign irq_event[`DSG_EVT_DEEP_ENTRY]  = (next_state == DSG_ST_DEEP) && (state != DSG_ST_DEEP);
    assign irq_event[`DSG_EVT_GATE_CHANGE] = gate_change;

    dsg_irq_bank #(
        .N (`DSG_EVT_N)
    ) u_irq (
        .sys_clk_i   (sys_clk_i),
        .reset_i     (reset_i),
        .event_i     (irq_event),
        .wr_enable_i (wr_irq_enable),
        .wr_clear_i  (wr_irq_clear),
        .wr_data_i   (wr_data_i[`DSG_EVT_N-1:0]),
        .status_o    (irq_status),
        .enable_o    (irq_enable),
        .irq_o       (irq_o)
    );

    // read decode; unmapped and write-only offsets read zero
    always_comb begin
        next_rd_data = `DSG_ZERO_WORD;
        if (addr_i == `DSG_OFF_RUN_GATE) begin
            next_rd_data = run_gate_ctrl_one;
        end else if (addr_i == `DSG_OFF_SLEEP_GATE) begin
            next_rd_data = sleep_gate_ctrl_one;
        end else if (addr_i == `DSG_OFF_DEEP_GATE) begin
            next_rd_data = deep_sleep_gate_ctrl_one;
        end else if (addr_i == `DSG_OFF_RUN_CLK_CFG) begin
            next_rd_data = run_clock_config;
        end else if (addr_i == `DSG_OFF_IRQ_STATUS) begin
            next_rd_data[`DSG_EVT_N-1:0] = irq_status;
        end else if (addr_i == `DSG_OFF_IRQ_ENABLE) begin
            next_rd_data[`DSG_EVT_N-1:0] = irq_enable;
        end
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_o <= `DSG_ZERO_WORD;
        end else if (rd_i) begin
            rd_data_o <= next_rd_data;
        end else begin
            rd_data_o <= `DSG_ZERO_WORD;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    // one flop per unit, so every gate follows its selected bit one edge later
    AST_COMP_ZERO_GATE: assert property (
        gate_en_o[7] == $past(eff_word[`DSG_COMP_ZERO_BIT]))
        else $error("comparator 0 gate does not follow its bit");

    AST_TIMER_TWO_GATE: assert property (
        gate_en_o[6] == $past(eff_word[`DSG_TIMER_TWO_BIT]))
        else $error("timer 2 gate does not follow its bit");

    AST_TIMER_ONE_GATE: assert property (
        gate_en_o[5] == $past(eff_word[`DSG_TIMER_ONE_BIT]))
        else $error("timer 1 gate does not follow its bit");

    AST_TIMER_ZERO_GATE: assert property (
        gate_en_o[4] == $past(eff_word[`DSG_TIMER_ZERO_BIT]))
        else $error("timer 0 gate does not follow its bit");

    AST_I2C_ZERO_GATE: assert property (
        gate_en_o[3] == $past(eff_word[`DSG_I2C_ZERO_BIT]))
        else $error("i2c 0 gate does not follow its bit");

    AST_SYNC_SERIAL_GATE: assert property (
        gate_en_o[2] == $past(eff_word[`DSG_SYNC_SERIAL_BIT]))
        else $error("serial 0 gate does not follow its bit");

    AST_UART_ONE_GATE: assert property (
        gate_en_o[1] == $past(eff_word[`DSG_UART_ONE_BIT]))
        else $error("uart 1 gate does not follow its bit");

    AST_UART_ZERO_GATE: assert property (
        gate_en_o[0] == $past(eff_word[`DSG_UART_ZERO_BIT]))
        else $error("uart 0 gate does not follow its bit");

    AST_DEEP_WRITE_TO_GATE: assert property (
        (wr_i && addr_i == `DSG_OFF_DEEP_GATE && auto_gating_select
         && state == DSG_ST_DEEP && next_state == DSG_ST_DEEP)
        ##1 (state == DSG_ST_DEEP && auto_gating_select)
        |=> gate_en_o[0] == $past(wr_data_i[`DSG_UART_ZERO_BIT], 2))
        else $error("deep-sleep write did not reach the uart 0 gate in two cycles");

    AST_FAULT_ON_GATED: assert property (
        (unit_req_i[3] && !gate_en_o[3]) |=> bus_fault_o[3] ##1 !bus_fault_o[3] || $past(unit_req_i[3]))
        else $error("access to gated i2c unit gave no single fault pulse");

    AST_NO_FAULT_WHEN_CLOCKED: assert property (
        gate_en_o[4] |=> !bus_fault_o[4])
        else $error("fault raised on a clocked timer unit");

    AST_FAULT_PER_UNIT: assert property (
        bus_fault_o == $past(unit_req_i & ~gate_en_o))
        else $error("fault pulses do not match requests to unclocked units");

    AST_FAULT_SETS_STATUS: assert property (
        |(unit_req_i & ~gate_en_o) |=> irq_status[`DSG_EVT_FAULT])
        else $error("fault did not set its status bit");

    // triggered by reset itself, so the flops have had one edge to clear
    AST_RESET_UNCLOCKED: assert property (
        @(posedge sys_clk_i) disable iff (1'b0)
        reset_i |=> (gate_en_o == '0 && deep_sleep_gate_ctrl_one == `DSG_GATE_RESET))
        else $error("units clocked during reset");

    AST_RESERVED_ZERO: assert property (
        (rd_i && addr_i == `DSG_OFF_DEEP_GATE) |=> (rd_data_o & ~`DSG_GATE_MASK) == `DSG_ZERO_WORD)
        else $error("reserved bits of the deep-sleep register read nonzero");

    AST_RESERVED_WRITE_IGNORED: assert property (
        (wr_i && addr_i == `DSG_OFF_DEEP_GATE) |=> (deep_sleep_gate_ctrl_one & ~`DSG_GATE_MASK) == `DSG_ZERO_WORD)
        else $error("reserved bits of the deep-sleep register took a write");

    AST_RUN_IGNORES_DEEP: assert property (
        (state == DSG_ST_RUN) |=> gate_en_o[7] == $past(run_gate_ctrl_one[`DSG_COMP_ZERO_BIT]))
        else $error("deep-sleep register acted outside deep-sleep");

    AST_AUTO_DEEP_SELECT: assert property (
        (state == DSG_ST_DEEP && auto_gating_select)
        |=> gate_en_o[2] == $past(deep_sleep_gate_ctrl_one[`DSG_SYNC_SERIAL_BIT]))
        else $error("deep-sleep register not applied with auto gating set");

    AST_AUTO_SLEEP_SELECT: assert property (
        (state == DSG_ST_SLEEP && auto_gating_select)
        |=> gate_en_o[3] == $past(sleep_gate_ctrl_one[`DSG_I2C_ZERO_BIT]))
        else $error("sleep register not applied with auto gating set");

    AST_NO_AUTO_RUN_SELECT: assert property (
        (state != DSG_ST_RUN && !auto_gating_select)
        |=> gate_en_o[6] == $past(run_gate_ctrl_one[`DSG_TIMER_TWO_BIT]))
        else $error("run register not applied with auto gating clear");

    // power state, interrupt bank and read port
    AST_STATE_FOLLOWS_MODE: assert property (
        (power_mode_i == `DSG_MODE_DEEP) |=> state == DSG_ST_DEEP)
        else $error("deep-sleep mode input not taken into the state");

    AST_DEEP_ENTRY_STATUS: assert property (
        (state != DSG_ST_DEEP && next_state == DSG_ST_DEEP) |=> irq_status[`DSG_EVT_DEEP_ENTRY])
        else $error("deep-sleep entry did not set its status bit");

    AST_GATE_CHANGE_STATUS: assert property (
        gate_change |=> irq_status[`DSG_EVT_GATE_CHANGE])
        else $error("gate change did not set its status bit");

    AST_IRQ_LEVEL: assert property (
        irq_o == |(irq_status & irq_enable))
        else $error("interrupt level does not match enabled status");

    AST_RD_DATA_IDLE: assert property (
        !rd_i |=> rd_data_o == `DSG_ZERO_WORD)
        else $error("read data stands outside the cycle after a read");

    // covers for the main scenarios
    COV_DEEP_AUTO: cover property (
        state == DSG_ST_DEEP && auto_gating_select && gate_en_o != '0);

    COV_FAULT: cover property (
        |bus_fault_o ##1 irq_o);

    COV_SLEEP_NO_AUTO: cover property (
        state == DSG_ST_SLEEP && !auto_gating_select && gate_en_o != '0);

    COV_DEEP_ENTRY: cover property (
        state != DSG_ST_DEEP ##1 state == DSG_ST_DEEP);

    COV_IRQ_CLEARED: cover property (
        irq_o ##1 !irq_o);

endmodule // dsg_gate_ctrl

// *** sim/dsg_gate_ctrl_tb.sv ***
// Purpose: self-checking bench for the deep-sleep gate block
// Assumes: 10 MHz clock, async active-high reset, register read data one cycle after the strobe
// Notes:   reference model in plain integers; event bits modelled from faults, mode and gate changes
`timescale 1ns/1ps
`include "dsg_defs.svh"

module dsg_gate_ctrl_tb
    import dsg_pkg::*;
;
    // design ports
    logic               sys_clk_i    = 1'b0;
    logic               reset_i      = 1'b1;
    logic [11:0]        addr_i       = 12'h000;
    dsg_word_type       wr_data_i    = 32'h0000_0000;
    logic               wr_i         = 1'b0;
    logic               rd_i         = 1'b0;
    logic [31:0]        rd_data_o;
    logic [1:0]         power_mode_i = 2'h0;
    logic [7:0]         unit_req_i   = 8'h00;
    logic [7:0]         gate_en_o;
    logic [7:0]         bus_fault_o;
    logic               irq_o;
    // model and bookkeeping
    int                 err_total    = 0;
    int                 n_compared   = 0;
    int                 cyc          = 0;
    int                 m_run, m_sleep, m_deep, m_cfg, m_en, m_st, m_mode;
    int                 bp[8]        = '{0, 1, 4, 12, 16, 17, 18, 24};
    logic [11:0]        offs[8]      = '{12'h060, 12'h104, 12'h114, 12'h124, 12'h130, 12'h134, 12'h138, 12'h128};
    logic [31:0]        v;

    dsg_gate_ctrl uut (
        .sys_clk_i    (sys_clk_i),
        .reset_i      (reset_i),
        .addr_i       (addr_i),
        .wr_data_i    (wr_data_i),
        .wr_i         (wr_i),
        .rd_i         (rd_i),
        .rd_data_o    (rd_data_o),
        .power_mode_i (power_mode_i),
        .unit_req_i   (unit_req_i),
        .gate_en_o    (gate_en_o),
        .bus_fault_o  (bus_fault_o),
        .irq_o        (irq_o)
    );

    always #50 sys_clk_i = ~sys_clk_i;

    // the whole run needs a few hundred cycles; a hang stops here
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done;
        end
    end

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // run register unless auto gating is on in sleep or deep-sleep; mode 3 counts as run
    function automatic logic [7:0] exp_gate(input int m);
        int s;
        s = m_run;
        if (m_cfg != 0 && m == 1) s = m_sleep;
        if (m_cfg != 0 && m == 2) s = m_deep;
        for (int k = 0; k < 8; k++) exp_gate[k] = s[bp[k]];
    endfunction

    function automatic logic [31:0] exp_rd(input logic [11:0] a);
        case (a)
            `DSG_OFF_RUN_CLK_CFG: exp_rd = m_cfg;
            `DSG_OFF_RUN_GATE:    exp_rd = m_run;
            `DSG_OFF_SLEEP_GATE:  exp_rd = m_sleep;
            `DSG_OFF_DEEP_GATE:   exp_rd = m_deep;
            `DSG_OFF_IRQ_STATUS:  exp_rd = m_st;
            `DSG_OFF_IRQ_ENABLE:  exp_rd = m_en;
            default:              exp_rd = 32'h0000_0000;
        endcase
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [7:0] g0;
        g0 = exp_gate(m_mode);
        @(posedge sys_clk_i);
        wr_i      <= 1'b1;
        addr_i    <= a;
        wr_data_i <= d;
        @(posedge sys_clk_i);
        wr_i      <= 1'b0;
        case (a)
            `DSG_OFF_RUN_CLK_CFG: m_cfg = d & 32'h0800_0000;
            `DSG_OFF_RUN_GATE:    m_run = d & `DSG_GATE_MASK;
            `DSG_OFF_SLEEP_GATE:  m_sleep = d & `DSG_GATE_MASK;
            `DSG_OFF_DEEP_GATE:   m_deep = d & `DSG_GATE_MASK;
            `DSG_OFF_IRQ_ENABLE:  m_en = d & 7;
            `DSG_OFF_IRQ_CLEAR:   m_st = m_st & ~(d & 7);
            default:              ;
        endcase
        if (exp_gate(m_mode) != g0) m_st |= 4;
    endtask

    task automatic rchk(input logic [11:0] a);
        @(posedge sys_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1 chk(rd_data_o, exp_rd(a));
    endtask

    task automatic mode(input int m);
        logic [7:0] g0;
        g0 = exp_gate(m_mode);
        @(posedge sys_clk_i);
        power_mode_i <= m[1:0];
        if (m == 2 && m_mode != 2) m_st |= 2;
        m_mode = m;
        if (exp_gate(m_mode) != g0) m_st |= 4;
    endtask

    // mode to gate takes two cycles, one more for margin
    task automatic settle;
        repeat (3) @(posedge sys_clk_i);
        #1 chk(gate_en_o, exp_gate(m_mode));
    endtask

    task automatic fault(input logic [7:0] r);
        logic [7:0] f;
        f = r & ~exp_gate(m_mode);
        @(posedge sys_clk_i);
        unit_req_i <= r;
        @(posedge sys_clk_i);
        unit_req_i <= 8'h00;
        #1 chk(bus_fault_o, f);
        if (f != 0) m_st |= 1;
    endtask

    task automatic irqchk;
        @(posedge sys_clk_i);
        #1 chk(irq_o, (m_st & m_en) != 0);
    endtask

    initial begin
        {m_run, m_sleep, m_deep, m_cfg, m_en, m_st, m_mode} = '0;
        void'($urandom(36430));
        repeat (4) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        settle;
        for (int i = 0; i < 8; i++) rchk(offs[i]);
        $display("test reset done");

        // random data everywhere, reserved, read-only and unmapped places included
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 8; i++) wr(offs[i], $urandom);
            for (int i = 0; i < 8; i++) rchk(offs[i]);
            settle;
        end
        $display("test registers done");

        for (int c = 0; c < 2; c++) begin
            wr(`DSG_OFF_RUN_CLK_CFG, ($urandom & 32'hf7ff_ffff) | (c << 27));
            for (int m = 0; m < 4; m++) begin
                mode(m);
                for (int r = 0; r < 3; r++) begin
                    wr(offs[1 + r], $urandom);
                    settle;
                end
                rchk(`DSG_OFF_IRQ_STATUS);
                wr(`DSG_OFF_IRQ_CLEAR, 32'h0000_0007);
            end
        end
        mode(2);
        for (int k = 0; k < 8; k++) begin
            wr(`DSG_OFF_DEEP_GATE, 32'h0000_0001 << bp[k]);
            settle;
        end
        // read-modify-write that writes the reserved bits back as read
        rchk(`DSG_OFF_DEEP_GATE);
        wr(`DSG_OFF_DEEP_GATE, m_deep | 32'h0000_0010);
        settle;
        $display("test gating done");

        wr(`DSG_OFF_IRQ_CLEAR, 32'h0000_0007);
        wr(`DSG_OFF_IRQ_ENABLE, 32'h0000_0000);
        wr(`DSG_OFF_DEEP_GATE, $urandom);
        wr(`DSG_OFF_IRQ_CLEAR, 32'h0000_0007);
        for (int i = 0; i < 6; i++) fault($urandom);
        fault(~exp_gate(m_mode));
        fault(exp_gate(m_mode));
        irqchk;
        rchk(`DSG_OFF_IRQ_STATUS);
        wr(`DSG_OFF_IRQ_ENABLE, 32'h0000_0001);
        irqchk;
        wr(`DSG_OFF_IRQ_CLEAR, 32'h0000_0001);
        irqchk;
        rchk(`DSG_OFF_IRQ_STATUS);
        $display("test fault done");

        // reset in mid-run with the mode input still at deep-sleep
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        {m_run, m_sleep, m_deep, m_cfg, m_en, m_st} = '0;
        if (m_mode == 2) m_st = 2;
        rchk(`DSG_OFF_DEEP_GATE);
        rchk(`DSG_OFF_IRQ_STATUS);
        settle;
        $display("test mid-run reset done");
        test_done;
    end
endmodule // dsg_gate_ctrl_tb
